// File: rtl/icfg_defs.vh
/*
  Constants of the I2C speed and target configuration block:
  register offsets, field positions, reset values, timing counts.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef ICFG_DEFS_VH
`define ICFG_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define ICFG_OFF_CTRL 8'h00
`define ICFG_OFF_TARGET 8'h04
`define ICFG_OFF_ENABLE 8'h0c
`define ICFG_OFF_STATE 8'h10
`define ICFG_OFF_RAW 8'h14

// ************************************************************
// Field positions
// ************************************************************
`define ICFG_CTRL_MASTER 0
`define ICFG_CTRL_SPD_LO 1
`define ICFG_CTRL_SPD_HI 2
`define ICFG_CTRL_WIDE 4
`define ICFG_CTRL_RESP_OFF 6
`define ICFG_TAR_SPECIAL 11
`define ICFG_TAR_GC_START 10
`define ICFG_TAR_ADDR_HI 9
`define ICFG_EN_ON 0
`define ICFG_STATE_TX_EMPTY 2
`define ICFG_RAW_TX_ABORT 6

// ************************************************************
// Reset values
// ************************************************************
`define ICFG_RST_SPEED 2'h2
`define ICFG_RST_MASTER 1'h1
`define ICFG_RST_RESP_OFF 1'h1
`define ICFG_RST_WIDE 1'h0
`define ICFG_RST_TARGET 12'h055
`define ICFG_RST_ENABLE 1'h0

// ************************************************************
// Speed codes and spike filter timing
// ************************************************************
`define ICFG_SPD_STD 2'h1
`define ICFG_SPD_FAST 2'h2
`define ICFG_SPD_HIGH 2'h3
`define ICFG_CLK_MHZ 50
`define ICFG_SPK_STD_NS 50
`define ICFG_SPK_FAST_NS 50
`define ICFG_SPK_HIGH_NS 10
`define ICFG_SPK_ULTRA_NS 10

`endif

// File: rtl/icfg_sync_filter.v
/*
  Two-flop synchroniser followed by a spike filter of selectable length.
  Assumes the pin is asynchronous to pclk and the length is static-ish.
*/
`timescale 1ns/1ns
`default_nettype none

module icfg_sync_filter
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Pin and filter length
  input wire pin_in,
  input wire [3:0] flt_len,
  // Filtered level
  output reg pin_filt
);

  reg sync1_reg; // First stage, read only by second stage
  reg sync2_reg; // Second stage, usable level
  reg [3:0] cnt_reg; // Cycles the new level has held

  // ************************************************************
  // Synchroniser and filter
  // ************************************************************
  // New level is taken only after it holds flt_len cycles
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      cnt_reg <= 4'h0;
      pin_filt <= 1'b1;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      if (sync2_reg == pin_filt)
        cnt_reg <= 4'h0;
      else if (cnt_reg + 4'h1 >= flt_len)
      begin
        pin_filt <= sync2_reg;
        cnt_reg <= 4'h0;
      end
      else
        cnt_reg <= cnt_reg + 4'h1;
    end
  end

endmodule // icfg_sync_filter

`default_nettype wire

// File: rtl/icfg_cmd_gate.v
/*
  Checks each queued master command against the addressing mode.
  Assumes cmd_valid is a one-cycle pulse from logic on pclk.
*/
`timescale 1ns/1ns
`default_nettype none

module icfg_cmd_gate
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Command in
  input wire cmd_valid,
  input wire cmd_read,
  // Mode
  input wire master_on,
  input wire gc_active,
  input wire loop_simplex,
  // Verdict pulses
  output reg cmd_accept,
  output reg cmd_abort
);

  // ************************************************************
  // Verdict
  // ************************************************************
  // Reads abort in general call and in one-way loopback
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_accept <= 1'b0;
      cmd_abort <= 1'b0;
    end
    else
    begin
      cmd_accept <= cmd_valid & master_on & ~(cmd_read & (gc_active | loop_simplex));
      cmd_abort <= cmd_valid & master_on & cmd_read & (gc_active | loop_simplex);
    end
  end

endmodule // icfg_cmd_gate

`default_nettype wire

// File: rtl/icfg_top.v
/*
  APB configuration slave of an I2C controller: speed mode with clamping,
  master and responder enables, the target address register, special
  command decode, loopback detect and the bus line spike filters.
  Assumes a 50 MHz pclk, an APB master, and command and FIFO status
  signals from logic on the same clock; bus lines arrive asynchronously.

*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "icfg_defs.vh"

module icfg_top
#(
  parameter [1:0] TOP_RATE_SETTING = 2'h3, // Highest speed built
  parameter ULTRA_RATE_OPTION = 0 // One builds the ultra mode
)
(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Controller status and commands
  input wire tx_fifo_empty,
  input wire cmd_valid,
  input wire cmd_read,
  input wire [9:0] own_slave_address,
  // Bus lines
  input wire scl_in,
  input wire sda_in,
  // Configuration out
  output reg master_on,
  output reg responder_on,
  output reg wide_addr_initiator,
  output reg block_on,
  output reg [1:0] active_speed,
  output reg [9:0] target_address,
  output reg send_general_call,
  output reg send_startbyte,
  output reg loopback_simplex,
  // Command verdicts
  output wire cmd_accept,
  output wire transmit_abort,
  // Filtered lines
  output wire scl_filt,
  output wire sda_filt,
  output reg scl_rise,
  output reg scl_fall
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Cycles for a spike time, rounded up, at least one
  function [3:0] spike_cycles;
    input integer ns;
    integer tmp;
    begin
      tmp = (ns * `ICFG_CLK_MHZ + 999) / 1000;
      if (tmp < 1)
        tmp = 1;
      spike_cycles = tmp[3:0];
    end
  endfunction

  // Illegal speed codes become the built maximum
  function [1:0] clamp_speed;
    input [1:0] req;
    begin
      if (req < `ICFG_SPD_STD || req > TOP_RATE_SETTING)
        clamp_speed = TOP_RATE_SETTING;
      else
        clamp_speed = req;
    end
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  reg [1:0] speed_reg; // Stored speed code
  reg master_reg; // Master enable
  reg resp_off_reg; // Responder disabled
  reg wide_reg; // Wide addressing for master
  reg [11:0] target_reg; // Target address register
  reg enable_reg; // Controller enable
  reg abort_flag_reg; // Sticky transmit abort
  reg scl_prev_reg; // Filtered clock one cycle ago
  reg [3:0] flt_len_reg; // Spike filter length in cycles
  // Address decode and APB phases
  wire setup_ph = psel & ~penable;
  wire wr_done = psel & penable & pready & pwrite; // Completing write
  wire hit_ctrl = (paddr == `ICFG_OFF_CTRL);
  wire hit_tar = (paddr == `ICFG_OFF_TARGET);
  wire hit_en = (paddr == `ICFG_OFF_ENABLE);
  wire hit_state = (paddr == `ICFG_OFF_STATE);
  wire hit_raw = (paddr == `ICFG_OFF_RAW);
  wire mapped = hit_ctrl | hit_tar | hit_en | hit_state | hit_raw; // Any register addressed
  // Identity query bit lies outside the twelve bits, so reads as clear
  wire gc_mode = target_reg[`ICFG_TAR_SPECIAL] & ~target_reg[`ICFG_TAR_GC_START];
  wire loop_match = (target_reg[`ICFG_TAR_ADDR_HI:0] == own_slave_address); // Target equals own address
  reg [31:0] rd_mux; // Readback value

  // ************************************************************
  // APB handshake
  // ************************************************************
  // No wait state: pready rises with the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else if (setup_ph)
    begin
      // Answer prepared during setup
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? 32'h0 : rd_mux;
    end
    else
    begin
      // Release after the completing edge
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  // ************************************************************
  // Readback
  // ************************************************************
  // Unused and reserved bits read as zero
  always @*
  begin
    rd_mux = 32'h0;
    if (hit_ctrl)
    begin
      rd_mux[`ICFG_CTRL_MASTER] = master_reg;
      rd_mux[`ICFG_CTRL_SPD_HI:`ICFG_CTRL_SPD_LO] = speed_reg;
      rd_mux[`ICFG_CTRL_WIDE] = wide_reg;
      rd_mux[`ICFG_CTRL_RESP_OFF] = resp_off_reg;
    end
    else if (hit_tar)
      rd_mux[11:0] = target_reg;
    else if (hit_en)
      rd_mux[`ICFG_EN_ON] = enable_reg;
    else if (hit_state)
      rd_mux[`ICFG_STATE_TX_EMPTY] = tx_fifo_empty;
    else if (hit_raw)
      rd_mux[`ICFG_RAW_TX_ABORT] = abort_flag_reg;
  end

  // ************************************************************
  // Control register
  // ************************************************************
  // Speed, master, wide addressing and responder bits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_reg <= `ICFG_RST_SPEED;
      master_reg <= `ICFG_RST_MASTER;
      wide_reg <= `ICFG_RST_WIDE;
      resp_off_reg <= `ICFG_RST_RESP_OFF;
    end
    else if (wr_done && hit_ctrl)
    begin
      speed_reg <= clamp_speed(pwdata[`ICFG_CTRL_SPD_HI:`ICFG_CTRL_SPD_LO]);
      master_reg <= pwdata[`ICFG_CTRL_MASTER];
      wide_reg <= pwdata[`ICFG_CTRL_WIDE];
      resp_off_reg <= pwdata[`ICFG_CTRL_RESP_OFF];
    end
  end

  // ************************************************************
  // Target address and enable registers
  // ************************************************************
  // Target holds its value while the block is enabled
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_reg <= `ICFG_RST_TARGET;
      enable_reg <= `ICFG_RST_ENABLE;
    end
    else
    begin
      if (wr_done && hit_tar && !enable_reg)
        target_reg <= pwdata[11:0];
      if (wr_done && hit_en)
        enable_reg <= pwdata[`ICFG_EN_ON];
    end
  end

  // ************************************************************
  // Transmit abort flag
  // ************************************************************
  // Write one clears; a new abort in the same cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      abort_flag_reg <= 1'b0;
    else if (transmit_abort)
      abort_flag_reg <= 1'b1;
    else if (wr_done && hit_raw && pwdata[`ICFG_RAW_TX_ABORT])
      abort_flag_reg <= 1'b0;
  end

  // ************************************************************
  // Configuration outputs
  // ************************************************************
  // Registered copies of the decoded configuration
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_on <= 1'b0;
      responder_on <= 1'b0;
      wide_addr_initiator <= 1'b0;
      block_on <= 1'b0;
      active_speed <= 2'h0;
      target_address <= 10'h0;
      send_general_call <= 1'b0;
      send_startbyte <= 1'b0;
      loopback_simplex <= 1'b0;
    end
    else
    begin
      master_on <= master_reg & enable_reg;
      responder_on <= ~resp_off_reg & enable_reg;
      wide_addr_initiator <= wide_reg;
      block_on <= enable_reg;
      // Ultra build ignores the speed field
      if (ULTRA_RATE_OPTION == 1)
        active_speed <= 2'h0;
      else
        active_speed <= speed_reg;
      // Address is suppressed during general call
      if (gc_mode)
        target_address <= 10'h0;
      else
        target_address <= target_reg[`ICFG_TAR_ADDR_HI:0];
      send_general_call <= gc_mode;
      send_startbyte <= target_reg[`ICFG_TAR_SPECIAL] & target_reg[`ICFG_TAR_GC_START];
      // Self addressing runs one way, master to own responder
      loopback_simplex <= loop_match & master_reg & ~resp_off_reg
        & ~target_reg[`ICFG_TAR_SPECIAL];
    end
  end

  // ************************************************************
  // Spike filter length
  // ************************************************************
  // Length follows speed in master and responder roles alike
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flt_len_reg <= 4'h1;
    else if (ULTRA_RATE_OPTION == 1)
      flt_len_reg <= spike_cycles(`ICFG_SPK_ULTRA_NS);
    else
      case (speed_reg)
        `ICFG_SPD_STD: flt_len_reg <= spike_cycles(`ICFG_SPK_STD_NS);
        `ICFG_SPD_FAST: flt_len_reg <= spike_cycles(`ICFG_SPK_FAST_NS);
        `ICFG_SPD_HIGH: flt_len_reg <= spike_cycles(`ICFG_SPK_HIGH_NS);
        default: flt_len_reg <= spike_cycles(`ICFG_SPK_FAST_NS);
      endcase
  end

  // ************************************************************
  // Line filters and clock edges
  // ************************************************************
  // Clock line filter
  icfg_sync_filter u_scl_flt
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(scl_in),
    .flt_len(flt_len_reg),
    .pin_filt(scl_filt)
  );

  // Data line filter
  icfg_sync_filter u_sda_flt
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sda_in),
    .flt_len(flt_len_reg),
    .pin_filt(sda_filt)
  );

  // Edge pulses of the filtered clock line
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_prev_reg <= 1'b1;
      scl_rise <= 1'b0;
      scl_fall <= 1'b0;
    end
    else
    begin
      scl_prev_reg <= scl_filt;
      scl_rise <= scl_filt & ~scl_prev_reg;
      scl_fall <= ~scl_filt & scl_prev_reg;
    end
  end

  // ************************************************************
  // Command gate
  // ************************************************************
  // Judges queued commands against general call and loopback
  icfg_cmd_gate u_gate
  (
    .pclk(pclk),
    .presetn(presetn),
    .cmd_valid(cmd_valid),
    .cmd_read(cmd_read),
    .master_on(master_on),
    .gc_active(send_general_call),
    .loop_simplex(loopback_simplex),
    .cmd_accept(cmd_accept),
    .cmd_abort(transmit_abort)
  );

endmodule // icfg_top

`default_nettype wire

// File: verif/icfg_bus_model.sv
/*
  Far-side bus device model: drives the clock and data lines in frames.
  Assumes pulled-up lines; the link clock stands high outside frames.
*/
`timescale 1ns/1ns
`default_nettype none

module icfg_bus_model
(
  // Frame control
  input wire logic run,
  // Bus lines
  output logic scl,
  output logic sda
);
  // ****
  // Frame generator, 160 ns link period
  // ****
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
    #7;
    forever
    begin
      if (run)
      begin
        // Data moves only while the clock is low
        #80 scl = 1'b0;
        #40 sda = ~sda;
        #40 scl = 1'b1;
      end
      else
      begin
        // Released line returns to the pull-up level
        sda = 1'b1;
        #10;
      end
    end
  end
endmodule // icfg_bus_model

`default_nettype wire

// File: verif/icfg_top_monitor.sv
/*
  Checker of the configuration block, bound to its top module.
  Assumes one pclk domain and presetn active low.
*/
`timescale 1ns/1ns
`default_nettype none

module icfg_top_monitor
#(
  parameter [1:0] TOP_RATE_SETTING = 2'h3 // Highest speed built
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB answer
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Commands
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [9:0] own_slave_address,
  // Configuration and verdicts
  input wire logic master_on,
  input wire logic responder_on,
  input wire logic block_on,
  input wire logic [1:0] active_speed,
  input wire logic [9:0] target_address,
  input wire logic send_general_call,
  input wire logic send_startbyte,
  input wire logic loopback_simplex,
  input wire logic cmd_accept,
  input wire logic transmit_abort,
  input wire logic scl_filt,
  input wire logic scl_rise
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_speed_legal: assert property ($past(presetn) |-> active_speed >= 2'h1 && active_speed <= TOP_RATE_SETTING)
    else $error("speed out of range");
  a_master_gated: assert property (master_on |-> block_on)
    else $error("master on while block off");
  a_resp_gated: assert property (responder_on |-> block_on)
    else $error("responder on while block off");
  a_special_one: assert property (!(send_general_call && send_startbyte))
    else $error("both special commands");
  a_gc_noaddr: assert property (send_general_call |-> target_address == 10'h000)
    else $error("address used in general call");
  a_target_frozen: assert property (block_on && $past(block_on) |-> $stable(target_address))
    else $error("target changed while enabled");
  a_gc_persist: assert property (block_on && $past(block_on) |-> $stable(send_general_call))
    else $error("general call mode changed while enabled");
  a_loop_match: assert property (loopback_simplex |-> target_address == $past(own_slave_address) && !send_startbyte)
    else $error("loopback without address match");
  a_gc_abort: assert property (cmd_valid && cmd_read && master_on && send_general_call |=> transmit_abort && !cmd_accept)
    else $error("read not aborted in general call");
  a_off_silent: assert property (cmd_valid && !master_on |=> !cmd_accept && !transmit_abort)
    else $error("verdict while master off");
  a_tar_reserved: assert property (pready && !pwrite && paddr == 8'h04 |-> prdata[31:12] == 20'h00000)
    else $error("reserved target bits set");
  a_rise_pulse: assert property ($rose(scl_filt) |=> scl_rise)
    else $error("missing rise pulse");
endmodule // icfg_top_monitor

bind icfg_top icfg_top_monitor #(.TOP_RATE_SETTING(TOP_RATE_SETTING)) mon_u (.pclk(pclk), .presetn(presetn),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
  .own_slave_address(own_slave_address), .master_on(master_on), .responder_on(responder_on), .block_on(block_on),
  .active_speed(active_speed), .target_address(target_address), .send_general_call(send_general_call),
  .send_startbyte(send_startbyte), .loopback_simplex(loopback_simplex), .cmd_accept(cmd_accept),
  .transmit_abort(transmit_abort), .scl_filt(scl_filt), .scl_rise(scl_rise));

`default_nettype wire

// File: verif/icfg_top_bench.sv
/*
  Self-checking bench of the configuration block with a bus-line model.
  Assumes the design header on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "icfg_defs.vh"
`define CHK(got, exp) begin samples_checked = samples_checked + 1; if ((got) !== (exp)) begin \
  fail_count = fail_count + 1; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module icfg_top_bench;
  // Stimulus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic tx_empty = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic link_run = 1'b0;
  logic [9:0] own = 10'h3c0;
  // Design outputs
  wire [31:0] prdata;
  wire pready, pslverr, scl_in, sda_in, master_on, resp_on, wide, block_on;
  wire gc, sb, loop, acc, abrt, scl_rise, scl_fall, scl_f, sda_f;
  wire [1:0] speed;
  wire [9:0] tar;
  // Bench state
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rises = 0;
  int wire_rises = 0;
  int falls = 0;
  int r0, w0, f0;
  logic [31:0] rd;
  logic er;
  logic [72:0] rows [0:7]; // Address, write data, read data, error

  icfg_top #(.TOP_RATE_SETTING(2'h2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_empty(tx_empty), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .own_slave_address(own),
    .scl_in(scl_in), .sda_in(sda_in), .master_on(master_on), .responder_on(resp_on), .wide_addr_initiator(wide),
    .block_on(block_on), .active_speed(speed), .target_address(tar), .send_general_call(gc), .send_startbyte(sb),
    .loopback_simplex(loop), .cmd_accept(acc), .transmit_abort(abrt), .scl_filt(scl_f), .sda_filt(sda_f),
    .scl_rise(scl_rise), .scl_fall(scl_fall));
  icfg_bus_model link_u (.run(link_run), .scl(scl_in), .sda(sda_in));

  // ****
  // Clock, timeout and counters
  // ****
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (scl_rise === 1'b1)
      rises <= rises + 1;
    if (scl_fall === 1'b1)
      falls <= falls + 1;
    if (cycles == 20000)
    begin
      fail_count = fail_count + 1;
      summarize();
    end
  end
  always @(posedge scl_in) wire_rises <= wire_rises + 1;

  // One APB transfer; waits for pready, only the bench timeout ends the wait
  task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Let configuration outputs follow their registers
  task settle();
    repeat (3) @(posedge pclk);
  endtask
  // One command pulse; verdict is seen on return
  task cmd(input logic r);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_read <= r;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    rows = '{{8'h00, 32'h43, 32'h43, 1'b0}, {8'h00, 32'h47, 32'h45, 1'b0}, {8'h00, 32'h41, 32'h45, 1'b0},
      {8'h00, 32'h55, 32'h55, 1'b0}, {8'h00, 32'h04, 32'h04, 1'b0}, {8'h04, 32'hfffffabc, 32'habc, 1'b0},
      {8'h04, 32'h123, 32'h123, 1'b0}, {8'h20, 32'h1, 32'h0, 1'b1}};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(`ICFG_OFF_CTRL, 32'h0, 1'b0);
    `CHK(rd, 32'h45)
    apb(`ICFG_OFF_TARGET, 32'h0, 1'b0);
    `CHK({rd, speed}, {32'h55, 2'h2})
    apb(`ICFG_OFF_CTRL, 32'h04, 1'b1);
    apb(`ICFG_OFF_ENABLE, 32'h1, 1'b1);
    settle();
    `CHK({master_on, resp_on, block_on, tar}, {3'b011, 10'h055})
    apb(`ICFG_OFF_ENABLE, 32'h0, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      apb(rows[i][72:65], rows[i][64:33], 1'b1);
      apb(rows[i][72:65], 32'h0, 1'b0);
      settle();
      `CHK({er, rd}, {rows[i][0], rows[i][32:1]})
      if (rows[i][72:65] == `ICFG_OFF_CTRL)
        `CHK({wide, speed}, {rows[i][5], rows[i][3:2]})
    end
    $display("test table done");
    apb(`ICFG_OFF_CTRL, 32'h45, 1'b1);
    apb(`ICFG_OFF_ENABLE, 32'h1, 1'b1);
    settle();
    `CHK({master_on, resp_on, block_on}, 3'b101)
    apb(`ICFG_OFF_TARGET, 32'h2aa, 1'b1);
    apb(`ICFG_OFF_TARGET, 32'h0, 1'b0);
    `CHK(rd, 32'h123)
    tx_empty <= 1'b0;
    apb(`ICFG_OFF_STATE, 32'h0, 1'b0);
    `CHK(rd[`ICFG_STATE_TX_EMPTY], 1'b0)
    cmd(1'b1);
    `CHK({acc, abrt}, 2'b10)
    $display("test enable done");
    apb(`ICFG_OFF_ENABLE, 32'h0, 1'b1);
    apb(`ICFG_OFF_TARGET, 32'h9aa, 1'b1);
    apb(`ICFG_OFF_ENABLE, 32'h1, 1'b1);
    settle();
    `CHK({gc, sb, tar}, {2'b10, 10'h000})
    cmd(1'b0);
    `CHK({acc, abrt}, 2'b10)
    cmd(1'b1);
    `CHK({acc, abrt}, 2'b01)
    cmd(1'b0);
    cmd(1'b1);
    `CHK({gc, abrt}, 2'b11)
    apb(`ICFG_OFF_RAW, 32'h0, 1'b0);
    `CHK(rd[`ICFG_RAW_TX_ABORT], 1'b1)
    apb(`ICFG_OFF_RAW, 32'h40, 1'b1);
    apb(`ICFG_OFF_RAW, 32'h0, 1'b0);
    `CHK(rd[`ICFG_RAW_TX_ABORT], 1'b0)
    $display("test general call done");
    apb(`ICFG_OFF_ENABLE, 32'h0, 1'b1);
    apb(`ICFG_OFF_TARGET, 32'hd55, 1'b1);
    settle();
    `CHK({gc, sb, tar}, {2'b01, 10'h155})
    cmd(1'b1);
    `CHK({acc, abrt}, 2'b00)
    apb(`ICFG_OFF_TARGET, 32'h555, 1'b1);
    apb(`ICFG_OFF_CTRL, 32'h05, 1'b1);
    own <= 10'h155;
    apb(`ICFG_OFF_ENABLE, 32'h1, 1'b1);
    settle();
    `CHK({gc, sb, loop}, 3'b001)
    cmd(1'b1);
    `CHK({acc, abrt}, 2'b01)
    own <= 10'h156;
    settle();
    `CHK(loop, 1'b0)
    $display("test special done");
    for (int s = 1; s < 3; s++)
    begin
      apb(`ICFG_OFF_CTRL, 32'h41 | (s << 1), 1'b1);
      r0 = rises;
      w0 = wire_rises;
      f0 = falls;
      link_run <= 1'b1;
      repeat (100) @(posedge pclk);
      link_run <= 1'b0;
      repeat (40) @(posedge pclk);
      `CHK(rises - r0, wire_rises - w0)
      `CHK(wire_rises - w0 > 5, 1'b1)
      `CHK(falls - f0, rises - r0)
      `CHK({scl_f, sda_f}, {1'b1, sda_in})
    end
    $display("test link done");
    summarize();
  end
endmodule // icfg_top_bench

`undef CHK
`default_nettype wire
